// [verilog/iolpm_map.svh]
// constants of the io-link port mode and parameter store block
`ifndef IOLPM_MAP_SVH
`define IOLPM_MAP_SVH

// register offsets
`define IOLPM_ADDR_W        4
`define IOLPM_REG_MODE      4'h0
`define IOLPM_REG_STORE     4'h1
`define IOLPM_REG_PDLEN     4'h2
`define IOLPM_REG_IDENT     4'h3
`define IOLPM_REG_STATUS    4'h4
`define IOLPM_REG_PARAM     4'h5

// port mode codes
`define IOLPM_MODE_DI       3'h0
`define IOLPM_MODE_SIO      3'h1
`define IOLPM_MODE_DO       3'h2
`define IOLPM_MODE_OFF      3'h3
`define IOLPM_MODE_COM      3'h4

// parameter storage codes
`define IOLPM_PS_DISABLED   3'h0
`define IOLPM_PS_DOWNLOAD   3'h1
`define IOLPM_PS_UPLOAD     3'h2
`define IOLPM_PS_BOTH       3'h3
`define IOLPM_PS_CLEAR      3'h4

// process data length limits
`define IOLPM_PD_MIN        6'h01
`define IOLPM_PD_MAX        6'h20

// upload request command
`define IOLPM_CMD_INDEX     16'h0002
`define IOLPM_CMD_SUB       8'h00
`define IOLPM_CMD_VALUE     8'h05

// reset values
`define IOLPM_RST_MODE      3'h3
`define IOLPM_RST_PD        6'h01

`endif

// [verilog/iolpm_pkg.sv]
// types of the io-link port mode and parameter store block
`default_nettype none
package iolpm_pkg;
    typedef enum logic [2:0] {
        IOLPM_IDLE     = 3'b000,
        IOLPM_CHECK    = 3'b001,
        IOLPM_UPLOAD   = 3'b010,
        IOLPM_DOWNLOAD = 3'b011,
        IOLPM_RUN      = 3'b100,
        IOLPM_REFUSED  = 3'b101
    } iolpm_state_t;
endpackage : iolpm_pkg
`default_nettype wire

// [verilog/iolpm_port.sv]
// per-port mode control and parameter storage decision for an io-link master
//
// How it works
// RL1 - digital input samples pin, never communicates
// RL2 - sio mode: parameterize at startup, then fall back
// RL3 - com control bit switches sio port into com
// RL4 - input state frozen during sio com episode
// RL5 - digital output drives pin, no communication
// RL6 - inactive mode switches sensor supply off
// RL7 - com mode starts link at device rate
// RL8 - process data length 1 to 32, clamped into range
// RL9 - storage disabled by default, set unchanged
// RL10 - download only when stored set usable
// RL11 - download-only compares, downloads unless locked
// RL12 - upload modes upload when no valid set
// RL13 - upload request command forces overwriting upload
// RL14 - combined mode keeps uploaded set stored
// RL15 - combined mode compares, downloads unless locked
// RL16 - action table selects upload or download
// RL17 - disabled-and-cleared erases the stored set
// RL18 - device raises upload flag after block write
// RL19 - validation refuses devices with wrong identity
// RL20 - storage actions only during a com episode
`timescale 1ns/1ps
`default_nettype none
`include "iolpm_map.svh"

module iolpm_port (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic        com_ctrl,
    input  wire logic        pin_in,
    input  wire logic        dev_present,
    input  wire logic        link_up,
    input  wire logic [7:0]  dev_rate,
    input  wire logic        dev_data_valid,
    input  wire logic        dev_upload_flag,
    input  wire logic        dev_locked,
    input  wire logic        dev_data_equal,
    input  wire logic [31:0] dev_ident,
    input  wire logic        xfer_done,
    output logic             supply_en,
    output logic             pin_out,
    output logic             pin_oe,
    output logic             link_start,
    output logic      [7:0]  link_rate,
    output logic      [5:0]  pd_len,
    output logic             do_upload,
    output logic             do_download,
    output logic             param_wr,
    output logic      [15:0] param_index,
    output logic      [7:0]  param_sub,
    output logic      [7:0]  param_value,
    output logic             di_state
);

    // ****************************************
    // configuration registers
    // ****************************************
    logic [2:0]  port_mode;
    logic [2:0]  store_mode;
    logic [5:0]  pd_cfg;
    logic [31:0] ident_cfg;
    logic        ident_check;
    logic        do_level;
    logic        store_valid;
    logic        startup_done;
    logic        com_active;
    logic        dev_present_q;
    logic        sync_a;
    logic        sync_b;
    logic        dev_new;
    iolpm_pkg::iolpm_state_t state;
    iolpm_pkg::iolpm_state_t next_state;

    // clamp the requested length into the legal window
    function automatic logic [5:0] fit_len(input logic [5:0] v);
        if (v < `IOLPM_PD_MIN)
            fit_len = `IOLPM_PD_MIN;
        else if (v > `IOLPM_PD_MAX)
            fit_len = `IOLPM_PD_MAX;
        else
            fit_len = v;
    endfunction : fit_len

    // register writes
    always_ff @(posedge clk) begin
        if (rst) begin
            port_mode   <= `IOLPM_RST_MODE;
            store_mode  <= `IOLPM_PS_DISABLED; // RL9
            pd_cfg      <= `IOLPM_RST_PD;
            ident_cfg   <= 32'h00000000;
            ident_check <= 1'b0;
            do_level    <= 1'b0;
        end else if (wr) begin
            case (addr)
                `IOLPM_REG_MODE: begin
                    port_mode <= wdata[2:0];
                    do_level  <= wdata[8];
                end
                `IOLPM_REG_STORE: store_mode <= wdata[2:0];
                `IOLPM_REG_PDLEN: pd_cfg <= fit_len(wdata[5:0]); // RL8
                `IOLPM_REG_IDENT: begin
                    ident_cfg   <= wdata;
                    ident_check <= 1'b1;
                end
                `IOLPM_REG_STATUS: ident_check <= wdata[0];
                default: ;
            endcase
        end
    end

    // pin input synchroniser
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= pin_in;
            sync_b <= sync_a;
        end
    end

    // ****************************************
    // port mode logic
    // ****************************************

    // com episode: com mode, sio startup, or com request from controller
    always_ff @(posedge clk) begin
        if (rst) begin
            com_active   <= 1'b0;
            startup_done <= 1'b0;
        end else begin
            if (port_mode == `IOLPM_MODE_SIO && state == iolpm_pkg::IOLPM_RUN)
                startup_done <= 1'b1; // RL2
            else if (port_mode != `IOLPM_MODE_SIO)
                startup_done <= 1'b0;
            if (port_mode == `IOLPM_MODE_COM)
                com_active <= 1'b1; // RL7
            else if (port_mode == `IOLPM_MODE_SIO)
                com_active <= com_ctrl || !startup_done; // RL3
            else
                com_active <= 1'b0; // RL1 RL5
        end
    end

    // pin drive, supply and link outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            supply_en  <= 1'b0;
            pin_out    <= 1'b0;
            pin_oe     <= 1'b0;
            link_start <= 1'b0;
            link_rate  <= 8'h00;
            pd_len     <= `IOLPM_RST_PD;
        end else begin
            supply_en  <= port_mode != `IOLPM_MODE_OFF; // RL6
            pin_oe     <= port_mode == `IOLPM_MODE_DO; // RL5
            pin_out    <= port_mode == `IOLPM_MODE_DO && do_level; // RL5
            link_start <= com_active && dev_present_q && state != iolpm_pkg::IOLPM_REFUSED; // RL7
            link_rate  <= dev_rate; // RL7
            pd_len     <= pd_cfg; // RL8
        end
    end

    // digital input image, held while communicating
    always_ff @(posedge clk) begin
        if (rst)
            di_state <= 1'b0;
        else if (!com_active && port_mode != `IOLPM_MODE_DO && port_mode != `IOLPM_MODE_OFF)
            di_state <= sync_b; // RL1 RL4
    end

    // ****************************************
    // parameter storage
    // ****************************************

    always_ff @(posedge clk) begin
        if (rst)
            dev_present_q <= 1'b0;
        else
            dev_present_q <= dev_present;
    end

    assign dev_new = dev_present && !dev_present_q;

    // decision state machine
    always_comb begin
        next_state = state;
        unique case (state)
            iolpm_pkg::IOLPM_IDLE:
                if (dev_new && com_active && link_up) // RL20
                    next_state = (ident_check && dev_ident != ident_cfg) ?
                                 iolpm_pkg::IOLPM_REFUSED : iolpm_pkg::IOLPM_CHECK; // RL19
                else if (dev_new && com_active)
                    next_state = iolpm_pkg::IOLPM_CHECK;
            iolpm_pkg::IOLPM_CHECK:
                if (!dev_present)
                    next_state = iolpm_pkg::IOLPM_IDLE;
                else if (link_up) begin
                    if (ident_check && dev_ident != ident_cfg)
                        next_state = iolpm_pkg::IOLPM_REFUSED; // RL19
                    else if ((store_mode == `IOLPM_PS_UPLOAD || store_mode == `IOLPM_PS_BOTH)
                             && ((!store_valid && dev_data_valid) || (store_valid && dev_upload_flag)))
                        next_state = iolpm_pkg::IOLPM_UPLOAD; // RL12 RL13 RL16
                    else if ((store_mode == `IOLPM_PS_DOWNLOAD || store_mode == `IOLPM_PS_BOTH)
                             && store_valid && !dev_data_equal && !dev_locked)
                        next_state = iolpm_pkg::IOLPM_DOWNLOAD; // RL10 RL11 RL15 RL16
                    else
                        next_state = iolpm_pkg::IOLPM_RUN; // RL9
                end
            iolpm_pkg::IOLPM_UPLOAD,
            iolpm_pkg::IOLPM_DOWNLOAD:
                if (!dev_present)
                    next_state = iolpm_pkg::IOLPM_IDLE;
                else if (xfer_done)
                    next_state = iolpm_pkg::IOLPM_RUN;
            iolpm_pkg::IOLPM_RUN,
            iolpm_pkg::IOLPM_REFUSED:
                if (!dev_present || !com_active)
                    next_state = iolpm_pkg::IOLPM_IDLE;
            default: next_state = iolpm_pkg::IOLPM_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst)
            state <= iolpm_pkg::IOLPM_IDLE;
        else
            state <= next_state;
    end

    // transfer strobes
    always_ff @(posedge clk) begin
        if (rst) begin
            do_upload   <= 1'b0;
            do_download <= 1'b0;
        end else begin
            do_upload   <= next_state == iolpm_pkg::IOLPM_UPLOAD && state == iolpm_pkg::IOLPM_CHECK;
            do_download <= next_state == iolpm_pkg::IOLPM_DOWNLOAD && state == iolpm_pkg::IOLPM_CHECK;
        end
    end

    // stored set validity: set by finished upload, erased by clear mode
    always_ff @(posedge clk) begin
        if (rst)
            store_valid <= 1'b0;
        else if (state == iolpm_pkg::IOLPM_UPLOAD && xfer_done && dev_present)
            store_valid <= 1'b1; // RL13 RL14
        else if (store_mode == `IOLPM_PS_CLEAR)
            store_valid <= 1'b0; // RL17
    end

    // upload request command sent to the device on a write
    always_ff @(posedge clk) begin
        if (rst) begin
            param_wr    <= 1'b0;
            param_index <= 16'h0000;
            param_sub   <= 8'h00;
            param_value <= 8'h00;
        end else begin
            param_wr    <= wr && addr == `IOLPM_REG_PARAM && com_active; // RL13
            param_index <= `IOLPM_CMD_INDEX;
            param_sub   <= `IOLPM_CMD_SUB;
            param_value <= `IOLPM_CMD_VALUE;
        end
    end

    // register reads, data one cycle after strobe
    always_ff @(posedge clk) begin
        if (rst)
            rdata <= 32'h00000000;
        else if (rd) begin
            case (addr)
                `IOLPM_REG_MODE:   rdata <= {23'h000000, do_level, 5'h00, port_mode};
                `IOLPM_REG_STORE:  rdata <= {29'h00000000, store_mode};
                `IOLPM_REG_PDLEN:  rdata <= {26'h0000000, pd_cfg};
                `IOLPM_REG_IDENT:  rdata <= ident_cfg;
                `IOLPM_REG_STATUS: rdata <= {24'h000000, store_valid, state, com_active,
                                             di_state, supply_en, ident_check};
                default:           rdata <= 32'h00000000;
            endcase
        end else
            rdata <= 32'h00000000;
    end

    // ****************************************
    // checks
    // ****************************************

    AST_DI_NO_LINK: assert property (@(posedge clk) disable iff (rst) // RL1
        port_mode == `IOLPM_MODE_DI && $past(port_mode) == `IOLPM_MODE_DI |=> !link_start)
        else $error("link started in digital input mode");

    AST_SIO_COM_REQ: assert property (@(posedge clk) disable iff (rst) // RL3
        port_mode == `IOLPM_MODE_SIO && com_ctrl |=> com_active)
        else $error("com request ignored in sio mode");

    AST_DI_FROZEN: assert property (@(posedge clk) disable iff (rst) // RL4
        com_active |=> $stable(di_state))
        else $error("input image changed during com episode");

    AST_DO_DRIVE: assert property (@(posedge clk) disable iff (rst) // RL5
        port_mode == `IOLPM_MODE_DO |=> pin_oe && !com_active)
        else $error("output mode not driving pin");

    AST_OFF_SUPPLY: assert property (@(posedge clk) disable iff (rst) // RL6
        port_mode == `IOLPM_MODE_OFF |=> !supply_en)
        else $error("supply on in inactive mode");

    AST_PD_RANGE: assert property (@(posedge clk) disable iff (rst) // RL8
        pd_len >= `IOLPM_PD_MIN && pd_len <= `IOLPM_PD_MAX)
        else $error("process data length out of range");

    AST_NO_XFER_DISABLED: assert property (@(posedge clk) disable iff (rst) // RL9
        store_mode == `IOLPM_PS_DISABLED && $past(store_mode) == `IOLPM_PS_DISABLED |-> !do_upload && !do_download)
        else $error("transfer while storage disabled");

    AST_DL_LOCKED: assert property (@(posedge clk) disable iff (rst) // RL11
        state == iolpm_pkg::IOLPM_CHECK && link_up && dev_locked |=> state != iolpm_pkg::IOLPM_DOWNLOAD)
        else $error("download to locked device");

    AST_CLEAR: assert property (@(posedge clk) disable iff (rst) // RL17
        store_mode == `IOLPM_PS_CLEAR && state != iolpm_pkg::IOLPM_UPLOAD |=> !store_valid)
        else $error("stored set survived clear");

    AST_COM_ONLY: assert property (@(posedge clk) disable iff (rst) // RL20
        state == iolpm_pkg::IOLPM_IDLE && !com_active |=> state == iolpm_pkg::IOLPM_IDLE)
        else $error("storage action outside com mode");

    AST_SIO_FALLBACK: assert property (@(posedge clk) disable iff (rst) // RL2
        port_mode == `IOLPM_MODE_SIO && startup_done && !com_ctrl |=> !com_active)
        else $error("sio port did not fall back to input");

    AST_SUPPLY_ON: assert property (@(posedge clk) disable iff (rst) // RL6
        port_mode != `IOLPM_MODE_OFF |=> supply_en)
        else $error("supply off in an active mode");

    AST_COM_LINK: assert property (@(posedge clk) disable iff (rst) // RL7
        com_active && dev_present_q && state != iolpm_pkg::IOLPM_REFUSED |=> link_start)
        else $error("link not started in com episode");

    AST_LINK_RATE: assert property (@(posedge clk) disable iff (rst) // RL7
        !$past(rst) |-> link_rate == $past(dev_rate))
        else $error("link rate does not follow device rate");

    AST_PD_FOLLOW: assert property (@(posedge clk) disable iff (rst) // RL8
        !$past(rst) |-> pd_len == $past(pd_cfg))
        else $error("process data length not applied");

    AST_SET_KEPT: assert property (@(posedge clk) disable iff (rst) // RL9
        store_mode == `IOLPM_PS_DISABLED && state != iolpm_pkg::IOLPM_UPLOAD |=> $stable(store_valid))
        else $error("stored set changed while disabled");

    AST_DL_NEEDS_SET: assert property (@(posedge clk) disable iff (rst) // RL10
        do_download |-> store_valid)
        else $error("download without a stored set");

    AST_UPREQ_CMD: assert property (@(posedge clk) disable iff (rst) // RL13
        wr && addr == `IOLPM_REG_PARAM && com_active |=> param_wr && param_index == `IOLPM_CMD_INDEX
            && param_sub == `IOLPM_CMD_SUB && param_value == `IOLPM_CMD_VALUE)
        else $error("upload request command not sent");

    AST_UPLOAD_KEEP: assert property (@(posedge clk) disable iff (rst) // RL14
        state == iolpm_pkg::IOLPM_UPLOAD && xfer_done && dev_present |=> store_valid)
        else $error("uploaded set not kept");

    AST_REFUSE: assert property (@(posedge clk) disable iff (rst) // RL19
        state == iolpm_pkg::IOLPM_CHECK && dev_present && link_up && ident_check && dev_ident != ident_cfg
        |=> state == iolpm_pkg::IOLPM_REFUSED)
        else $error("device with wrong identity not refused");

endmodule : iolpm_port
`default_nettype wire

// [test/iolpm_dev_model.sv]
// behavioural io-link device standing on the far side of one port
`timescale 1ns/1ps
`default_nettype none

module iolpm_dev_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        dev_present,
    input  wire logic        block_wr,
    input  wire logic [31:0] ident_cfg,
    input  wire logic        link_start,
    input  wire logic        do_upload,
    input  wire logic        do_download,
    input  wire logic        param_wr,
    input  wire logic [31:0] cmd,
    output logic             link_up,
    output logic             dev_upload_flag,
    output logic             xfer_done,
    output logic      [31:0] dev_ident
);
    logic [1:0] busy;

    // link follows the master's request a cycle later, only while attached
    always_ff @(posedge clk) begin
        link_up <= !rst && dev_present && link_start;
    end

    // each transfer reports done two cycles after it was asked for
    always_ff @(posedge clk) begin
        if (rst) begin
            busy <= 2'h0;
        end else if (do_upload || do_download) begin
            busy <= 2'h2;
        end else if (busy != 2'h0) begin
            busy <= busy - 2'h1;
        end
    end
    assign xfer_done = (busy == 2'h1);

    // upload request flag, cleared as soon as the master starts the upload
    always_ff @(posedge clk) begin
        if (rst || do_upload) begin
            dev_upload_flag <= 1'b0;
        end else if (block_wr) begin
            dev_upload_flag <= 1'b1;
        end else if (param_wr && cmd == 32'h0002_0005) begin
            dev_upload_flag <= 1'b1;
        end
    end

    // unplugged identity lines show the inverse, never the last value
    assign dev_ident = dev_present ? ident_cfg : ~ident_cfg;
endmodule : iolpm_dev_model
`default_nettype wire

// [test/iolpm_port_tb_top.sv]
// self-checking bench of the port mode and parameter store block
`timescale 1ns/1ps
`default_nettype none

module iolpm_port_tb_top;
    logic        clk, rst = 1'b1, wr = 1'b0, rd = 1'b0, com_ctrl = 1'b0, pin_in = 1'b0, block_wr = 1'b0;
    logic        dev_present = 1'b0, dev_data_valid = 1'b1, dev_locked = 1'b0, dev_data_equal = 1'b0;
    logic        link_up, dev_upload_flag, xfer_done, supply_en, pin_out, pin_oe, link_start;
    logic        do_upload, do_download, param_wr, di_state;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  dev_rate = 8'h5a, link_rate, param_sub, param_value;
    logic [5:0]  pd_len;
    logic [15:0] param_index;
    logic [31:0] wdata = 32'h0, rdata, dev_ident, pw_word, d;
    logic [31:0] ident_cfg = 32'h5555_aaaa; // arbitrary identity value
    logic [5:0]  pl_in [5] = '{6'h00, 6'h01, 6'h11, 6'h20, 6'h21};
    logic [5:0]  pl_exp [5] = '{6'h01, 6'h01, 6'h11, 6'h20, 6'h20};
    int          num_errors = 0, n_tests = 0, n_up = 0, n_dn = 0, cycles = 0;

    iolpm_port iolpm_port_inst (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .com_ctrl(com_ctrl), .pin_in(pin_in), .dev_present(dev_present), .link_up(link_up),
        .dev_rate(dev_rate), .dev_data_valid(dev_data_valid), .dev_upload_flag(dev_upload_flag),
        .dev_locked(dev_locked), .dev_data_equal(dev_data_equal), .dev_ident(dev_ident),
        .xfer_done(xfer_done), .supply_en(supply_en), .pin_out(pin_out), .pin_oe(pin_oe),
        .link_start(link_start), .link_rate(link_rate), .pd_len(pd_len), .do_upload(do_upload),
        .do_download(do_download), .param_wr(param_wr), .param_index(param_index),
        .param_sub(param_sub), .param_value(param_value), .di_state(di_state)
    );

    iolpm_dev_model iolpm_dev_model_inst (
        .clk(clk), .rst(rst), .dev_present(dev_present), .block_wr(block_wr), .ident_cfg(ident_cfg),
        .link_start(link_start), .do_upload(do_upload), .do_download(do_download), .param_wr(param_wr),
        .cmd({param_index, param_sub, param_value}), .link_up(link_up),
        .dev_upload_flag(dev_upload_flag), .xfer_done(xfer_done), .dev_ident(dev_ident)
    );

    // 20 mhz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // transfer counters, command capture and hang guard
    always @(posedge clk) begin
        cycles++;
        if (do_upload === 1'b1) n_up++;
        if (do_download === 1'b1) n_dn++;
        if (param_wr === 1'b1) pw_word = {param_index, param_sub, param_value};
        if (cycles == 4000) begin
            num_errors++;
            final_report();
        end
    end

    task automatic final_report;
        if (num_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle

    // detach then attach the device and let any transfer finish
    task automatic plug;
        n_up = 0;
        n_dn = 0;
        @(posedge clk) dev_present <= 1'b0;
        repeat (3) @(posedge clk);
        dev_present <= 1'b1;
        idle(12);
    endtask : plug

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd_reg(4'h0);
        chk("reset mode", d, 32'h3);
        rd_reg(4'h1);
        chk("reset store", d, 32'h0);
        chk("reset outs", 32'({supply_en, pd_len}), 32'h01);
        rd_reg(4'hf);
        chk("unmapped", d, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr_reg(4'h2, 32'(pl_in[i]));
            rd_reg(4'h2);
            chk("pd length", d, 32'(pl_exp[i]));
            chk("pd port", 32'(pd_len), 32'(pl_exp[i]));
        end
        wr_reg(4'h1, 32'h2);
        wr_reg(4'h0, 32'h0);
        @(posedge clk) pin_in <= 1'b1;
        idle(5);
        chk("di outs", 32'({supply_en, pin_oe, link_start, di_state}), 32'h9);
        plug;
        chk("di uploads", n_up, 32'h0);
        wr_reg(4'h0, 32'h102);
        idle(3);
        chk("do outs", 32'({pin_oe, pin_out, link_start}), 32'h6);
        wr_reg(4'h0, 32'h3);
        idle(3);
        chk("off supply", 32'(supply_en), 32'h0);
        wr_reg(4'h0, 32'h4);
        idle(3);
        chk("com link", 32'({link_start, link_rate}), 32'h15a);
        plug;
        chk("first upload", n_up, 32'h1);
        rd_reg(4'h4);
        chk("stored", d & 32'h80, 32'h80);
        wr_reg(4'h1, 32'h1);
        @(posedge clk) dev_locked <= 1'b1;
        plug;
        chk("locked dl", n_dn, 32'h0);
        @(posedge clk) dev_locked <= 1'b0;
        plug;
        chk("diff dl", n_dn, 32'h1);
        @(posedge clk) dev_data_equal <= 1'b1;
        plug;
        chk("equal dl", n_dn, 32'h0);
        wr_reg(4'h1, 32'h0);
        @(posedge clk) dev_data_equal <= 1'b0;
        plug;
        chk("disabled xfers", n_up + n_dn, 32'h0);
        rd_reg(4'h4);
        chk("kept set", d & 32'h80, 32'h80);
        wr_reg(4'h1, 32'h3);
        wr_reg(4'h5, 32'h0);
        idle(2);
        chk("request cmd", pw_word, 32'h0002_0005);
        plug;
        chk("flag upload", n_up * 2 + n_dn, 32'h2);
        plug;
        chk("both dl", n_up * 2 + n_dn, 32'h1);
        @(posedge clk) block_wr <= 1'b1;
        @(posedge clk) block_wr <= 1'b0;
        plug;
        chk("block upload", n_up * 2 + n_dn, 32'h2);
        wr_reg(4'h1, 32'h4);
        idle(2);
        rd_reg(4'h4);
        chk("cleared", d & 32'h80, 32'h0);
        wr_reg(4'h1, 32'h1);
        plug;
        chk("no set dl", n_dn, 32'h0);
        @(posedge clk) dev_data_valid <= 1'b0;
        wr_reg(4'h1, 32'h2);
        plug;
        chk("invalid dev", n_up, 32'h0);
        @(posedge clk) dev_data_valid <= 1'b1;
        wr_reg(4'h1, 32'h2);
        wr_reg(4'h3, 32'h1234_5678);
        wr_reg(4'h4, 32'h1);
        plug;
        chk("refused up", n_up, 32'h0);
        rd_reg(4'h4);
        chk("refused state", d & 32'h70, 32'h50);
        wr_reg(4'h4, 32'h0);
        wr_reg(4'h0, 32'h1);
        rd_reg(4'h4);
        chk("sio startup", d & 32'h08, 32'h08);
        plug;
        chk("sio upload", n_up, 32'h1);
        @(posedge clk) pin_in <= 1'b0;
        idle(5);
        chk("sio fallback", 32'({link_start, di_state}), 32'h0);
        @(posedge clk) com_ctrl <= 1'b1;
        idle(3);
        chk("sio com", 32'(link_start), 32'h1);
        @(posedge clk) pin_in <= 1'b1;
        idle(5);
        chk("frozen di", 32'(di_state), 32'h0);
        @(posedge clk) com_ctrl <= 1'b0;
        idle(6);
        chk("di resumes", 32'({link_start, di_state}), 32'h1);
        final_report();
    end
endmodule : iolpm_port_tb_top
`default_nettype wire
